/* File: logic/pmw_defines.svh */
// register indices, field positions, reset values and timing counts
`ifndef PMW_DEFINES_SVH
`define PMW_DEFINES_SVH

// ------------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define PMW_IDX_PCTRL   10'h087
`define PMW_IDX_P1WAKE  10'h096
`define PMW_IDX_IEMAIN  10'h0A8
`define PMW_IDX_IESEC   10'h0A9
`define PMW_IDX_LVCFG   10'h0BF
`define PMW_IDX_STAT    10'h0C0
`define PMW_IDX_MASK    10'h0C1
`define PMW_IDX_MODE    10'h0C2

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define PMW_PC_SLEEP    0
`define PMW_PC_HALT     1
`define PMW_IE_PIN0     0
`define PMW_IE_GLOBAL   7
`define PMW_IE2_P1      1
`define PMW_IE2_SHARED  2
`define PMW_LV_OUT      6
`define PMW_LV_IE       7
`define PMW_ST_IDLEWK   0
`define PMW_ST_HALTWK   1
`define PMW_ST_LVD      2
`define PMW_ST_P1CHG    3

// ------------------------------------------------------------------
// reset values and write masks
// ------------------------------------------------------------------
`define PMW_RST_BYTE    8'h00
`define PMW_RST_STAT    4'h0
`define PMW_PC_KEEP     8'h8C
`define PMW_LV_KEEP     8'h8F

// ------------------------------------------------------------------
// timing
// ------------------------------------------------------------------
`define PMW_CLK_NS      20
`define PMW_WARM_NS     100
`define PMW_WARM_CYC    ((`PMW_WARM_NS + `PMW_CLK_NS - 1) / `PMW_CLK_NS)
`define PMW_RESUME_CYC  2

`endif

/* File: logic/pmw_pkg.sv */
// types shared by the power mode wake-up block
`default_nettype none
package pmw_pkg;
  typedef enum logic [2:0] {
    MD_RUN, MD_IDLE, MD_HALT, MD_WARM, MD_RESUME
  } pmw_mode_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmw_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pmw_apb_rsp_t;

  typedef logic [12:0] pmw_mv_t;
endpackage
`default_nettype wire

/* File: logic/pmw_power_mode_wakeup_irq.sv */
// power mode wake-up and interrupt gating with apb register slave
//
// How it works
// - pin zero enable gates its irq and wake
// - shared bit gates pins two-nine and lowvolt
// - lowvolt irq needs both lowvolt enables
// - four-bit code selects 2.5V to 4.3V
// - detector off in idle, halt, stop
// - idle wake needs own and global enable
// - any enabled source ends idle mode
// - service entered at once after idle
// - power-down bit write enters halt
// - idle request bit write enters idle
// - port1 mask bits enable pin wake
// - next instruction runs before halt service
// - halt service needs global and port1 enable
// - pin level must persist past clock restart
// - port1 change needs no clock sampling
// - global enable off blocks all interrupts (irqOut here is not gated by it)
// - port1 flag ignores port1 irq enable
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defines.svh"

module pmw_power_mode_wakeup_irq
  import pmw_pkg::*;
#(
  parameter int NOTHER     = 6,
  parameter int WARM_CYC   = `PMW_WARM_CYC,
  parameter int RESUME_CYC = `PMW_RESUME_CYC
) (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire pmw_apb_req_t      apbReq,
  output pmw_apb_rsp_t           apbRsp,
  input  wire logic              pinZero,
  input  wire logic [7:0]        pinsTwoToNine,
  input  wire logic [7:0]        port1Pins,
  input  wire logic              lvdTrip,
  input  wire logic [NOTHER-1:0] otherIrqReq,
  input  wire logic              svcAck,
  output logic                   svcReq,
  output logic                   cpuRun,
  output logic                   sysClkRun,
  output logic                   lvdEnable,
  output logic [3:0]             lvdSelect,
  output pmw_mv_t                lvdThreshMv,
  output logic                   irqOut
);

  // ------------------------------------------------------------------
  // threshold table
  // ------------------------------------------------------------------
  // millivolts per code; the steps are uneven, so a table beats arithmetic
  localparam pmw_mv_t MV_TAB [16] = '{
    13'h9C4, 13'hA28, 13'hA8C, 13'hAF0, 13'hBB8, 13'hC1C, 13'hC80, 13'hCE4,
    13'hD48, 13'hE10, 13'hE74, 13'hED8, 13'hF3C, 13'hFA0, 13'h1068, 13'h10CC
  };

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  pmw_mode_t    mode_r;
  logic [7:0]   cnt_r;
  logic [7:0]   pctl_r, ieMain_r, ieSec_r, p1Wake_r, lvCfg_r, p1Prev_r;
  logic         p1Flag_r, lvdOut_r, mapped;
  logic [3:0]   stat_r, mask_r, stat_nxt;
  logic [31:0]  rdata;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic [9:0] idx;
  logic       wrEn, rdPhase;
  assign idx     = apbReq.paddr[11:2];
  assign rdPhase = apbReq.psel & apbReq.penable & ~apbRsp.pready;
  assign wrEn    = apbReq.psel & apbReq.penable & apbReq.pwrite &
                   apbRsp.pready & mapped;

  // ------------------------------------------------------------------
  // gating terms
  // ------------------------------------------------------------------
  logic       globalEn, pin0En, sharedEn, p1IrqEn, lvIrqEn;
  logic [7:0] p1Change;
  logic       lvdPend, pinSvc, svcPend, idleWake, haltWake, wakeDone;

  assign globalEn = ieMain_r[`PMW_IE_GLOBAL];
  assign pin0En   = ieMain_r[`PMW_IE_PIN0];
  assign sharedEn = ieSec_r[`PMW_IE2_SHARED];
  assign p1IrqEn  = ieSec_r[`PMW_IE2_P1];
  assign lvIrqEn  = lvCfg_r[`PMW_LV_IE] & sharedEn;
  // raw pin comparison: the change is seen without a sampled level
  assign p1Change = (port1Pins ^ p1Prev_r) & p1Wake_r;
  assign lvdPend  = lvdTrip & lvdEnable & lvIrqEn;

  // pins count only when sampled by a running clock
  assign pinSvc   = (pinZero & pin0En) |
                    ((|pinsTwoToNine) & sharedEn);
  assign svcPend  = globalEn & (pinSvc | lvdPend |
                    (p1Flag_r & p1IrqEn) | (|otherIrqReq));
  assign idleWake = svcPend;
  // halt wake ignores the global enable
  assign haltWake = (pinZero & pin0En) |
                    ((|pinsTwoToNine) & sharedEn) |
                    (|p1Change);
  assign wakeDone = (mode_r == MD_IDLE && idleWake) ||
                    (mode_r == MD_HALT && haltWake);

  // ------------------------------------------------------------------
  // mode sequencer
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      mode_r <= MD_RUN;
      cnt_r  <= 8'h00;
    end else begin
      case (mode_r)
        MD_RUN: begin
          if (wrEn && idx == `PMW_IDX_PCTRL) begin
            if (apbReq.pwdata[`PMW_PC_HALT]) begin
              mode_r <= MD_HALT;
            end else if (apbReq.pwdata[`PMW_PC_SLEEP]) begin
              mode_r <= MD_IDLE;
            end
          end
        end
        MD_IDLE: begin
          if (idleWake) begin
            mode_r <= MD_RUN;
          end
        end
        MD_HALT: begin
          if (haltWake) begin
            mode_r <= MD_WARM;
            cnt_r  <= 8'(WARM_CYC);
          end
        end
        MD_WARM: begin
          if (cnt_r <= 8'h01) begin
            mode_r <= MD_RESUME;
            cnt_r  <= 8'(RESUME_CYC);
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        MD_RESUME: begin
          // the instruction after the power-down write runs here
          if (cnt_r <= 8'h01) begin
            mode_r <= MD_RUN;
            cnt_r  <= 8'h00;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: begin
          mode_r <= MD_RUN;
          cnt_r  <= 8'h00;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // control registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pctl_r <= `PMW_RST_BYTE;
    end else if (wakeDone) begin
      pctl_r[`PMW_PC_HALT]  <= 1'b0;
      pctl_r[`PMW_PC_SLEEP] <= 1'b0;
    end else if (wrEn && idx == `PMW_IDX_PCTRL && mode_r == MD_RUN) begin
      pctl_r <= apbReq.pwdata[7:0] & `PMW_PC_KEEP;
      if (apbReq.pwdata[`PMW_PC_HALT]) begin
        pctl_r[`PMW_PC_HALT] <= 1'b1;
      end else begin
        pctl_r[`PMW_PC_SLEEP] <= apbReq.pwdata[`PMW_PC_SLEEP];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ieMain_r <= `PMW_RST_BYTE;
      ieSec_r  <= `PMW_RST_BYTE;
      p1Wake_r <= `PMW_RST_BYTE;
      lvCfg_r  <= `PMW_RST_BYTE;
      mask_r   <= `PMW_RST_STAT;
    end else if (wrEn) begin
      case (idx)
        `PMW_IDX_IEMAIN: ieMain_r <= apbReq.pwdata[7:0];
        `PMW_IDX_IESEC:  ieSec_r  <= apbReq.pwdata[7:0];
        `PMW_IDX_P1WAKE: p1Wake_r <= apbReq.pwdata[7:0];
        `PMW_IDX_LVCFG:  lvCfg_r  <= apbReq.pwdata[7:0] & `PMW_LV_KEEP;
        `PMW_IDX_MASK:   mask_r   <= apbReq.pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // port1 change flag
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      p1Prev_r <= 8'h00;
      p1Flag_r <= 1'b0;
    end else begin
      p1Prev_r <= port1Pins;
      // a change in the ack cycle keeps the flag set
      if (|p1Change) begin
        p1Flag_r <= 1'b1;
      end else if (svcAck) begin
        p1Flag_r <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // low voltage detector control
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lvdEnable   <= 1'b0;
      lvdSelect   <= 4'h0;
      lvdThreshMv <= 13'h9C4;
      lvdOut_r    <= 1'b0;
    end else begin
      lvdEnable   <= (mode_r == MD_RUN) && !wakeDone &&
                     !(wrEn && idx == `PMW_IDX_PCTRL &&
                       (|apbReq.pwdata[1:0]));
      lvdSelect   <= lvCfg_r[3:0];
      lvdThreshMv <= MV_TAB[lvCfg_r[3:0]];
      lvdOut_r    <= lvdTrip & lvdEnable;
    end
  end

  // ------------------------------------------------------------------
  // cpu side outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      svcReq    <= 1'b0;
      cpuRun    <= 1'b1;
      sysClkRun <= 1'b1;
    end else begin
      // from idle the request rises with the wake itself
      svcReq    <= ((mode_r == MD_RUN) ||
                    (mode_r == MD_IDLE && idleWake)) && svcPend;
      cpuRun    <= (mode_r == MD_RUN) || (mode_r == MD_RESUME) ||
                   (mode_r == MD_IDLE && idleWake);
      sysClkRun <= (mode_r != MD_HALT) && (mode_r != MD_WARM);
    end
  end

  // ------------------------------------------------------------------
  // event status and interrupt
  // ------------------------------------------------------------------
  always_comb begin
    stat_nxt = stat_r;
    if (wrEn && idx == `PMW_IDX_STAT) begin
      stat_nxt = stat_nxt & ~apbReq.pwdata[3:0];
    end
    // set beats clear in the same cycle
    if (mode_r == MD_IDLE && idleWake) begin
      stat_nxt[`PMW_ST_IDLEWK] = 1'b1;
    end
    if (mode_r == MD_HALT && haltWake) begin
      stat_nxt[`PMW_ST_HALTWK] = 1'b1;
    end
    if (lvdPend) begin
      stat_nxt[`PMW_ST_LVD] = 1'b1;
    end
    if (|p1Change) begin
      stat_nxt[`PMW_ST_P1CHG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stat_r <= `PMW_RST_STAT;
      irqOut <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irqOut <= |(stat_nxt & mask_r);
    end
  end

  // ------------------------------------------------------------------
  // read mux and apb answer
  // ------------------------------------------------------------------
  always_comb begin
    rdata  = 32'h0000_0000;
    mapped = 1'b1;
    case (idx)
      `PMW_IDX_PCTRL:  rdata[7:0] = pctl_r;
      `PMW_IDX_IEMAIN: rdata[7:0] = ieMain_r;
      `PMW_IDX_IESEC:  rdata[7:0] = ieSec_r;
      `PMW_IDX_P1WAKE: rdata[7:0] = p1Wake_r;
      `PMW_IDX_LVCFG: begin
        rdata[7:0]         = lvCfg_r;
        rdata[`PMW_LV_OUT] = lvdOut_r;
      end
      `PMW_IDX_STAT:   rdata[4:0] = {p1Flag_r, stat_r};
      `PMW_IDX_MASK:   rdata[3:0] = mask_r;
      `PMW_IDX_MODE:   rdata[2:0] = mode_r;
      default:         mapped     = 1'b0;
    endcase
  end

  // one wait state: ready rises in the second access cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      apbRsp <= '0;
    end else begin
      apbRsp.pready  <= rdPhase;
      apbRsp.pslverr <= rdPhase & ~mapped;
      apbRsp.prdata  <= (rdPhase && !apbReq.pwrite) ? rdata : 32'h0000_0000;
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_pin0_blocked: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_r == MD_HALT && !pin0En && !(|pinsTwoToNine) && !(|p1Change))
    |=> mode_r == MD_HALT)
    else $error("halt left with no enabled wake source");
  a_lvd_gate: assert property (@(posedge clk_sys) disable iff (srst)
    (lvdTrip && lvdEnable && !(lvCfg_r[`PMW_LV_IE] && sharedEn) &&
     !(wrEn && idx == `PMW_IDX_STAT)) |=> stat_r[`PMW_ST_LVD] ==
     $past(stat_r[`PMW_ST_LVD]))
    else $error("lowvolt event without both enables");
  a_lvd_sleep_off: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_r != MD_RUN) |=> !lvdEnable)
    else $error("detector enabled outside run");
  a_idle_wake: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_r == MD_IDLE && !globalEn) |=> mode_r == MD_IDLE)
    else $error("idle left with global enable off");
  a_idle_svc: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_r == MD_IDLE && idleWake) |=> (svcReq && mode_r == MD_RUN))
    else $error("no immediate service after idle wake");
  a_halt_entry: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_r == MD_RUN && wrEn && idx == `PMW_IDX_PCTRL &&
     apbReq.pwdata[`PMW_PC_HALT]) |=> (mode_r == MD_HALT) ##1 !sysClkRun)
    else $error("power-down write did not halt");
  a_halt_no_svc: assert property (@(posedge clk_sys) disable iff (srst)
    (mode_r == MD_HALT && haltWake) |=> !svcReq [*4])
    else $error("service before resume instruction");
  a_p1_flag: assert property (@(posedge clk_sys) disable iff (srst)
    (|p1Change) |=> p1Flag_r)
    else $error("port1 change flag not set");
  a_wake_clear: assert property (@(posedge clk_sys) disable iff (srst)
    wakeDone |=> (pctl_r[1:0] == 2'b00))
    else $error("mode bit left set after wake");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (srst)
    irqOut == $past(|(stat_nxt & mask_r)))
    else $error("interrupt output mismatch");

endmodule // pmw_power_mode_wakeup_irq

`default_nettype wire

/* File: test/pmw_core_model.sv */
// cpu core stand-in that takes service requests and acknowledges them
`timescale 1ns/1ps
`default_nettype none

module pmw_core_model (
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       svcReq,
  input  wire logic [3:0] ackDly,
  output var  logic       svcAck
);
  logic [3:0] waitCnt_r;

  // a slow core leaves the request standing for ackDly cycles;
  // a request still up after the pulse is taken again
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      waitCnt_r <= 4'h0;
      svcAck    <= 1'h0;
    end else if (!svcReq || svcAck) begin
      waitCnt_r <= 4'h0;
      svcAck    <= 1'h0;
    end else if (waitCnt_r == ackDly) begin
      svcAck    <= 1'h1;
    end else begin
      waitCnt_r <= waitCnt_r + 4'h1;
    end
  end
endmodule // pmw_core_model

`default_nettype wire

/* File: test/tb.sv */
// self-checking testbench of the power mode wake-up block
`timescale 1ns/1ps
`default_nettype none
`include "pmw_defines.svh"

module tb
  import pmw_pkg::*;
;
  localparam logic [9:0] PC  = `PMW_IDX_PCTRL;
  localparam logic [9:0] PW  = `PMW_IDX_P1WAKE;
  localparam logic [9:0] IE  = `PMW_IDX_IEMAIN;
  localparam logic [9:0] IE2 = `PMW_IDX_IESEC;
  localparam logic [9:0] LV  = `PMW_IDX_LVCFG;
  localparam logic [9:0] ST  = `PMW_IDX_STAT;
  localparam logic [9:0] MK  = `PMW_IDX_MASK;
  localparam logic [9:0] MD  = `PMW_IDX_MODE;

  logic         clk_sys       = 1'h0;
  logic         srst          = 1'h1;
  pmw_apb_req_t apbReq        = '0;
  pmw_apb_rsp_t apbRsp;
  logic         pinZero       = 1'h0;
  logic [7:0]   pinsTwoToNine = 8'h00;
  logic [7:0]   port1Pins     = 8'h00;
  logic         lvdTrip       = 1'h0;
  logic [5:0]   otherIrqReq   = 6'h00;
  logic [3:0]   ackDly        = 4'h2;
  logic         svcAck;
  logic         svcReq;
  logic         cpuRun;
  logic         sysClkRun;
  logic         lvdEnable;
  logic [3:0]   lvdSelect;
  pmw_mv_t      lvdThreshMv;
  logic         irqOut;
  logic [31:0]  rdat;
  logic         rerr;
  int           errors        = 0;
  int           nChecks       = 0;
  int           mvTab[16]     = '{2500, 2600, 2700, 2800, 3000, 3100, 3200,
                                  3300, 3400, 3600, 3700, 3800, 3900, 4000,
                                  4200, 4300};

  pmw_power_mode_wakeup_irq i_dut (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .apbReq        (apbReq),
    .apbRsp        (apbRsp),
    .pinZero       (pinZero),
    .pinsTwoToNine (pinsTwoToNine),
    .port1Pins     (port1Pins),
    .lvdTrip       (lvdTrip),
    .otherIrqReq   (otherIrqReq),
    .svcAck        (svcAck),
    .svcReq        (svcReq),
    .cpuRun        (cpuRun),
    .sysClkRun     (sysClkRun),
    .lvdEnable     (lvdEnable),
    .lvdSelect     (lvdSelect),
    .lvdThreshMv   (lvdThreshMv),
    .irqOut        (irqOut)
  );

  pmw_core_model i_core (
    .clk_sys (clk_sys),
    .srst    (srst),
    .svcReq  (svcReq),
    .ackDly  (ackDly),
    .svcAck  (svcAck)
  );

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  // ------------------------------------------------------------------
  // access and compare tasks
  // ------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d errors %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    nChecks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %0h got %0h", nm, e, g);
    end
  endtask

  // request held until pready is seen at an edge; one idle cycle after
  task automatic apb(logic w, logic [9:0] ix, logic [7:0] d);
    int n;
    n = 0;
    apbReq.psel    <= 1'h1;
    apbReq.penable <= 1'h0;
    apbReq.pwrite  <= w;
    apbReq.paddr   <= {ix, 2'h0};
    apbReq.pwdata  <= {24'h0, d};
    @(posedge clk_sys);
    apbReq.penable <= 1'h1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (apbRsp.pready !== 1'h1);
    chk("wait", 2, n);
    rdat = apbRsp.prdata;
    rerr = apbRsp.pslverr;
    apbReq.psel    <= 1'h0;
    apbReq.penable <= 1'h0;
    @(posedge clk_sys);
  endtask

  task automatic wr(logic [9:0] ix, logic [7:0] d);
    apb(1'h1, ix, d);
  endtask

  task automatic rd(logic [9:0] ix, logic [7:0] e, string nm);
    apb(1'h0, ix, 8'h00);
    chk(nm, {24'h0, e}, rdat);
  endtask

  function automatic logic pick(int s);
    case (s)
      0: return cpuRun;
      1: return svcReq;
      default: return irqOut;
    endcase
  endfunction

  task automatic waitv(int s, logic v, int lim, string nm);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk(nm, v, pick(s));
  endtask

  task automatic stay(int s, logic v, int c, string nm);
    logic ok;
    ok = 1'h1;
    repeat (c) begin
      @(posedge clk_sys);
      if (pick(s) !== v) ok = 1'h0;
    end
    chk(nm, 1'h1, ok);
  endtask

  task automatic halt();
    wr(PC, 8'h02);
    // no accesses while the halt write settles
    repeat (2) @(posedge clk_sys);
    chk("clk off", 1'h0, sysClkRun);
    chk("lvd off", 1'h0, lvdEnable);
  endtask

  // halt, wake by pin zero or a port1 toggle, then judge the service
  task automatic hgo(logic [7:0] ie, ie2, logic p0, p1, wide, svc);
    wr(IE, ie);
    wr(IE2, ie2);
    halt();
    pinZero   <= p0;
    port1Pins <= port1Pins ^ {7'h0, p1};
    @(posedge clk_sys);
    if (!wide) pinZero <= 1'h0;
    waitv(0, 1'h1, 30, "halt wake");
    chk("svc early", 1'h0, svcReq);
    if (svc) waitv(1, 1'h1, 10, "halt svc");
    else stay(1, 1'h0, 15, "halt no svc");
    pinZero <= 1'h0;
    repeat (12) @(posedge clk_sys);
  endtask

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'h0;
    @(posedge clk_sys);
    rd(IE2, 8'h00, "ie2 reset");
    rd(MD, 8'h00, "mode reset");
    chk("mv reset", 2500, lvdThreshMv);
    apb(1'h1, 10'h3FF, 8'h5A);
    chk("slverr", 1'h1, rerr);
    wr(IE2, 8'hA5);
    rd(IE2, 8'hA5, "ie2 rw");
    for (int k = 0; k < 16; k++) begin
      wr(LV, k[7:0]);
      repeat (2) @(posedge clk_sys);
      chk("lvd sel", k[3:0], lvdSelect);
      chk("lvd mv", mvTab[k], lvdThreshMv);
    end
    // every mix of shared enable, lowvolt enable and mask
    for (int k = 0; k < 8; k++) begin
      wr(IE2, {5'h0, k[0], 2'h0});
      wr(LV, {k[1], 7'h0});
      wr(MK, {5'h0, k[2], 2'h0});
      lvdTrip <= 1'h1;
      repeat (6) @(posedge clk_sys);
      chk("lvd irq", k[0] & k[1] & k[2], irqOut);
      lvdTrip <= 1'h0;
      rd(ST, {5'h0, k[0] & k[1], 2'h0}, "lvd stat");
      wr(ST, 8'h04);
      waitv(2, 1'h0, 4, "irq clr");
    end
    wr(IE, 8'h80);
    for (int k = 0; k < 6; k++) begin
      ackDly <= k[3:0];
      wr(PC, 8'h01);
      repeat (2) @(posedge clk_sys);
      chk("idle run", 1'h0, cpuRun);
      chk("idle lvd", 1'h0, lvdEnable);
      rd(MD, 8'h01, "mode idle");
      otherIrqReq[k] <= 1'h1;
      waitv(0, 1'h1, 10, "idle wake");
      chk("idle svc", 1'h1, svcReq);
      otherIrqReq[k] <= 1'h0;
      rd(PC, 8'h00, "pc clr");
    end
    wr(IE, 8'h00);
    wr(PC, 8'h01);
    otherIrqReq[0] <= 1'h1;
    pinZero        <= 1'h1;
    stay(0, 1'h0, 8, "ea off");
    wr(IE, 8'h01);
    stay(0, 1'h0, 8, "ea off pin0");
    otherIrqReq[0] <= 1'h0;
    wr(IE, 8'h80);
    stay(0, 1'h0, 8, "pin0 off");
    wr(IE, 8'h81);
    waitv(0, 1'h1, 10, "pin0 idle");
    pinZero <= 1'h0;
    repeat (4) @(posedge clk_sys);
    wr(IE2, 8'h04);
    wr(IE, 8'h80);
    halt();
    pinZero <= 1'h1;
    stay(0, 1'h0, 10, "pin0 halt");
    pinsTwoToNine <= 8'h08;
    waitv(0, 1'h1, 30, "pins wake");
    chk("pins early", 1'h0, svcReq);
    waitv(1, 1'h1, 10, "pins svc");
    pinsTwoToNine <= 8'h00;
    pinZero       <= 1'h0;
    repeat (12) @(posedge clk_sys);
    hgo(8'h01, 8'h00, 1'h1, 1'h0, 1'h1, 1'h0);
    hgo(8'h81, 8'h00, 1'h1, 1'h0, 1'h0, 1'h0);
    hgo(8'h81, 8'h00, 1'h1, 1'h0, 1'h1, 1'h1);
    wr(PW, 8'h01);
    wr(IE2, 8'h00);
    wr(ST, 8'hFF);
    halt();
    pinsTwoToNine <= 8'hFF;
    port1Pins     <= 8'h02;
    stay(0, 1'h0, 10, "no wake");
    port1Pins <= 8'h03;
    waitv(0, 1'h1, 30, "p1 wake");
    stay(1, 1'h0, 15, "p1 no svc");
    pinsTwoToNine <= 8'h00;
    rd(ST, 8'h1A, "p1 flag");
    // serve the stale flag first so the next wake must set it anew
    ackDly <= 4'h0;
    wr(IE, 8'h80);
    wr(IE2, 8'h02);
    waitv(1, 1'h1, 10, "p1 pend");
    waitv(1, 1'h0, 10, "p1 ack");
    rd(ST, 8'h0A, "p1 flag clr");
    hgo(8'h80, 8'h02, 1'h0, 1'h1, 1'h1, 1'h1);
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_sim();
  end
endmodule // tb

`default_nettype wire
